//--- nsp_host.sv
`timescale 1ns/100ps
`include "nsp_cfg.svh"
module nsp_host
   import nsp_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // Device pins
   output logic ce_n_out,
   output logic cle_out,
   output logic ale_out,
   output logic we_n_out,
   output logic read_strobe_n_out,
   output logic [7:0] io_out,
   output logic io_oe_out,
   input wire logic [7:0] io_in,
   input wire logic ready_in
);
   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [7:0] io_s1_r, io_s2_r;
   logic rdy_s1_r, rdy_s2_r;

   always_ff @(posedge clk_in)
   begin
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
      rdy_s1_r <= ready_in;
      rdy_s2_r <= rdy_s1_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] cmd_code(input nsp_op_e op);
      case (op)
         OP_STATUS: cmd_code = `NSP_CMD_STATUS;
         OP_ESTATUS: cmd_code = `NSP_CMD_ESTATUS;
         OP_PARAM: cmd_code = `NSP_CMD_PARAM;
         OP_PSEL: cmd_code = `NSP_CMD_PSEL;
         default: cmd_code = `NSP_CMD_READMODE;
      endcase
   endfunction

   function automatic logic [2:0] addr_count(input nsp_op_e op);
      case (op)
         OP_ESTATUS: addr_count = 3'd3;
         OP_PARAM: addr_count = 3'd1;
         OP_PSEL: addr_count = 3'd5;
         default: addr_count = 3'd0;
      endcase
   endfunction

   // Literals cannot be part-selected, so multi-byte fields get names
   localparam logic [15:0] PP_SPARE_PAGE = `NSP_PP_SPARE_PAGE;
   localparam logic [31:0] PP_DATA_PART = `NSP_PP_DATA_PART;
   localparam logic [15:0] PP_SPARE_PART = `NSP_PP_SPARE_PART;
   localparam logic [31:0] PP_PAGES_BLK = `NSP_PP_PAGES_BLK;
   localparam logic [31:0] PP_BLKS_LUN = `NSP_PP_BLKS_LUN;
   localparam logic [15:0] PP_BAD_MAX = `NSP_PP_BAD_MAX;
   localparam logic [15:0] PP_T_PROG = `NSP_PP_T_PROG;
   localparam logic [15:0] PP_T_ERASE = `NSP_PP_T_ERASE;
   localparam logic [15:0] PP_T_READ = `NSP_PP_T_READ;
   localparam logic [15:0] PP_CCS_MIN = `NSP_PP_CCS_MIN;

   // Returns {check, expected byte} for a parameter page position
   function automatic logic [8:0] pp_expect(input logic [11:0] pos);
      logic [7:0] p;
      p = pos[7:0];
      pp_expect = 9'h000;
      if (pos < `NSP_PP_COPY_END)
      begin
         case (p)
            8'd84: pp_expect = {1'b1, PP_SPARE_PAGE[7:0]};
            8'd85: pp_expect = {1'b1, PP_SPARE_PAGE[15:8]};
            8'd86: pp_expect = {1'b1, PP_DATA_PART[7:0]};
            8'd87: pp_expect = {1'b1, PP_DATA_PART[15:8]};
            8'd88: pp_expect = {1'b1, PP_DATA_PART[23:16]};
            8'd89: pp_expect = {1'b1, PP_DATA_PART[31:24]};
            8'd90: pp_expect = {1'b1, PP_SPARE_PART[7:0]};
            8'd91: pp_expect = {1'b1, PP_SPARE_PART[15:8]};
            8'd92: pp_expect = {1'b1, PP_PAGES_BLK[7:0]};
            8'd93: pp_expect = {1'b1, PP_PAGES_BLK[15:8]};
            8'd94: pp_expect = {1'b1, PP_PAGES_BLK[23:16]};
            8'd95: pp_expect = {1'b1, PP_PAGES_BLK[31:24]};
            8'd96: pp_expect = {1'b1, PP_BLKS_LUN[7:0]};
            8'd97: pp_expect = {1'b1, PP_BLKS_LUN[15:8]};
            8'd98: pp_expect = {1'b1, PP_BLKS_LUN[23:16]};
            8'd99: pp_expect = {1'b1, PP_BLKS_LUN[31:24]};
            8'd100: pp_expect = {1'b1, `NSP_PP_LUNS};
            8'd103: pp_expect = {1'b1, PP_BAD_MAX[7:0]};
            8'd104: pp_expect = {1'b1, PP_BAD_MAX[15:8]};
            8'd110: pp_expect = {1'b1, `NSP_PP_NOP};
            8'd111: pp_expect = {1'b1, `NSP_PP_PART_ATTR};
            8'd112: pp_expect = {1'b1, `NSP_PP_ECC_BITS};
            8'd113: pp_expect = {1'b1, `NSP_PP_ILV_BITS};
            8'd114: pp_expect = {1'b1, `NSP_PP_ILV_ATTR};
            8'd133: pp_expect = {1'b1, PP_T_PROG[7:0]};
            8'd134: pp_expect = {1'b1, PP_T_PROG[15:8]};
            8'd135: pp_expect = {1'b1, PP_T_ERASE[7:0]};
            8'd136: pp_expect = {1'b1, PP_T_ERASE[15:8]};
            8'd137: pp_expect = {1'b1, PP_T_READ[7:0]};
            8'd138: pp_expect = {1'b1, PP_T_READ[15:8]};
            8'd139: pp_expect = {1'b1, PP_CCS_MIN[7:0]};
            8'd140: pp_expect = {1'b1, PP_CCS_MIN[15:8]};
            default: pp_expect = 9'h000;
         endcase
         // Second 256-byte slice is unused output, not checked
         if (pos >= `NSP_PP_COPY_LEN && pos < 12'd512)
            pp_expect = 9'h000;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers and sequencer
   nsp_state_e st_r, st_nxt;
   nsp_op_e op_r, op_nxt;
   logic otp_r, otp_nxt;
   logic [23:0] row_r, row_nxt;
   logic [15:0] col_r, col_nxt;
   logic [11:0] count_r, count_nxt;
   logic [11:0] idx_r, idx_nxt;
   logic [11:0] pos_r, pos_nxt;
   logic [7:0] wait_r, wait_nxt;
   logic sent_r, sent_nxt;
   logic smode_r, smode_nxt;
   logic refused_r, refused_nxt;
   logic mism_r, mism_nxt;
   logic [7:0] stat_r, stat_nxt;
   logic [7:0] data_r, data_nxt;
   logic ce_n_r, ce_n_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic start;
   nsp_req_s req;
   logic cyc_done;
   logic [7:0] cyc_data;
   nsp_pins_s pins;
   logic [11:0] nreads;
   logic [8:0] expect9;

   nsp_cycle u_cycle (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .start_in(start),
      .req_in(req),
      .done_out(cyc_done),
      .rd_data_out(cyc_data),
      .io_sync_in(io_s2_r),
      .pins_out(pins)
   );

   assign rdata_out = rdata_r;
   assign ce_n_out = ce_n_r;
   assign cle_out = pins.cle;
   assign ale_out = pins.ale;
   assign we_n_out = pins.we_n;
   assign read_strobe_n_out = pins.re_n;
   assign io_out = pins.io;
   assign io_oe_out = pins.io_oe;

   always_comb
   begin
      st_nxt = st_r;
      op_nxt = op_r;
      otp_nxt = otp_r;
      row_nxt = row_r;
      col_nxt = col_r;
      count_nxt = count_r;
      idx_nxt = idx_r;
      pos_nxt = pos_r;
      wait_nxt = wait_r;
      sent_nxt = sent_r;
      smode_nxt = smode_r;
      refused_nxt = refused_r;
      mism_nxt = mism_r;
      stat_nxt = stat_r;
      data_nxt = data_r;
      ce_n_nxt = ce_n_r;
      rdata_nxt = 32'h0000_0000;
      start = 1'b0;
      req = '{kind: KIND_CMD, data: cmd_code(op_r)};
      nreads = (op_r == OP_STATUS || op_r == OP_ESTATUS) ? 12'd1 :
               (op_r == OP_PARAM || op_r == OP_DATA) ? count_r : 12'd0;
      expect9 = pp_expect(pos_r);

      // Register writes
      if (wr_in && st_r == ST_IDLE)
      begin
         if (addr_in == `NSP_REG_CTRL)
         begin
            op_nxt = nsp_op_e'(wdata_in[`NSP_CTRL_OP_LSB +: 3]);
            otp_nxt = wdata_in[`NSP_CTRL_OTP_BIT];
            idx_nxt = 12'd0;
            sent_nxt = 1'b0;
            refused_nxt = 1'b0;
            if (nsp_op_e'(wdata_in[2:0]) == OP_ESTATUS && wdata_in[`NSP_CTRL_OTP_BIT])
               refused_nxt = 1'b1;
            else if (nsp_op_e'(wdata_in[2:0]) == OP_PSEL)
               st_nxt = ST_PRE_RDY;
            else if (nsp_op_e'(wdata_in[2:0]) == OP_DATA && !smode_r)
            begin
               ce_n_nxt = 1'b0;
               st_nxt = ST_READ;
            end
            else if (wdata_in[2:0] <= 3'd5)
            begin
               ce_n_nxt = 1'b0;
               st_nxt = ST_CMD1;
            end
            if (nsp_op_e'(wdata_in[2:0]) == OP_PARAM)
            begin
               pos_nxt = 12'd0;
               mism_nxt = 1'b0;
            end
         end
         else if (addr_in == `NSP_REG_ROW)
            row_nxt = wdata_in[23:0];
         else if (addr_in == `NSP_REG_COL)
            col_nxt = wdata_in[15:0];
         else if (addr_in == `NSP_REG_COUNT)
            count_nxt = wdata_in[11:0];
      end

      // Register reads
      if (rd_in)
      begin
         if (addr_in == `NSP_REG_CTRL)
            rdata_nxt = {28'h0, otp_r, op_r};
         else if (addr_in == `NSP_REG_ROW)
            rdata_nxt = {8'h00, row_r};
         else if (addr_in == `NSP_REG_COL)
            rdata_nxt = {16'h0000, col_r};
         else if (addr_in == `NSP_REG_COUNT)
            rdata_nxt = {20'h00000, count_r};
         else if (addr_in == `NSP_REG_STAT)
            rdata_nxt = {11'h000, !stat_r[`NSP_SR_WP_N], stat_r[`NSP_SR_PERR],
                         stat_r[`NSP_SR_FAIL], stat_r[`NSP_SR_RDY_ARR],
                         stat_r[`NSP_SR_RDY], stat_r, 4'h0, smode_r, mism_r,
                         refused_r, (st_r != ST_IDLE)};
         else if (addr_in == `NSP_REG_DATA)
            rdata_nxt = {4'h0, pos_r, 8'h00, data_r};
      end

      case (st_r)
         ST_PRE_RDY:
         begin
            if (rdy_s2_r)
            begin
               ce_n_nxt = 1'b0;
               st_nxt = ST_CMD1;
            end
         end
         ST_CMD1:
         begin
            start = !sent_r;
            sent_nxt = 1'b1;
            if (cyc_done)
            begin
               sent_nxt = 1'b0;
               if (op_r == OP_READMODE || op_r == OP_DATA)
                  pos_nxt = 12'd0;
               st_nxt = (addr_count(op_r) != 3'd0) ? ST_ADDR : ST_TWAIT;
               wait_nxt = (op_r == OP_PARAM) ? `NSP_WB_CYC : `NSP_WHR_CYC;
            end
         end
         ST_ADDR:
         begin
            start = !sent_r;
            sent_nxt = 1'b1;
            req.kind = KIND_ADDR;
            if (op_r == OP_PARAM)
               req.data = `NSP_PARAM_ADDR;
            else if (op_r == OP_PSEL && idx_r < 12'd2)
               req.data = col_r[idx_r[0]*8 +: 8];
            else if (op_r == OP_PSEL)
               req.data = row_r[(idx_r[2:0] - 3'd2)*8 +: 8];
            else
               req.data = row_r[idx_r[1:0]*8 +: 8];
            if (cyc_done)
            begin
               sent_nxt = 1'b0;
               idx_nxt = idx_r + 12'd1;
               if (idx_r[2:0] == addr_count(op_r) - 3'd1)
               begin
                  idx_nxt = 12'd0;
                  st_nxt = (op_r == OP_PSEL) ? ST_CMD2 : ST_TWAIT;
               end
            end
         end
         ST_CMD2:
         begin
            start = !sent_r;
            sent_nxt = 1'b1;
            req.data = `NSP_CMD_PSEL_CONF;
            if (cyc_done)
            begin
               sent_nxt = 1'b0;
               st_nxt = ST_TWAIT;
            end
         end
         ST_TWAIT:
         begin
            wait_nxt = wait_r - 8'd1;
            if (wait_r <= 8'd1)
            begin
               if (op_r == OP_PARAM)
                  st_nxt = ST_RDY;
               else
                  st_nxt = (nreads != 12'd0) ? ST_READ : ST_DONE;
            end
         end
         ST_RDY:
         begin
            // Parameter load busy; then honour the turnaround before reading
            if (rdy_s2_r)
            begin
               op_nxt = OP_DATA;
               wait_nxt = `NSP_WHR_CYC;
               st_nxt = ST_TWAIT;
            end
         end
         ST_READ:
         begin
            // Enhanced status is taken without waiting for ready
            start = !sent_r && (nreads != 12'd0);
            sent_nxt = 1'b1;
            req.kind = KIND_READ;
            if (nreads == 12'd0)
               st_nxt = ST_DONE;
            if (cyc_done)
            begin
               sent_nxt = 1'b0;
               idx_nxt = idx_r + 12'd1;
               if (op_r == OP_STATUS || op_r == OP_ESTATUS)
                  stat_nxt = cyc_data;
               else
               begin
                  data_nxt = cyc_data;
                  pos_nxt = pos_r + 12'd1;
                  if (expect9[8] && expect9[7:0] != cyc_data)
                     mism_nxt = 1'b1;
               end
               if (idx_r + 12'd1 >= nreads)
                  st_nxt = ST_DONE;
            end
         end
         ST_DONE:
         begin
            ce_n_nxt = 1'b1;
            idx_nxt = 12'd0;
            smode_nxt = (op_r == OP_STATUS || op_r == OP_ESTATUS);
            st_nxt = ST_IDLE;
         end
         default:
         begin
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= ST_IDLE;
         op_r <= OP_STATUS;
         otp_r <= 1'b0;
         row_r <= 24'h000000;
         col_r <= 16'h0000;
         count_r <= 12'h000;
         idx_r <= 12'h000;
         pos_r <= 12'h000;
         wait_r <= 8'h00;
         sent_r <= 1'b0;
         smode_r <= 1'b0;
         refused_r <= 1'b0;
         mism_r <= 1'b0;
         stat_r <= 8'h00;
         data_r <= 8'h00;
         ce_n_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         otp_r <= otp_nxt;
         row_r <= row_nxt;
         col_r <= col_nxt;
         count_r <= count_nxt;
         idx_r <= idx_nxt;
         pos_r <= pos_nxt;
         wait_r <= wait_nxt;
         sent_r <= sent_nxt;
         smode_r <= smode_nxt;
         refused_r <= refused_nxt;
         mism_r <= mism_nxt;
         stat_r <= stat_nxt;
         data_r <= data_nxt;
         ce_n_r <= ce_n_nxt;
         rdata_r <= rdata_nxt;
      end
   end
endmodule

//--- nsp_cfg.svh
`ifndef NSP_CFG_SVH
`define NSP_CFG_SVH

// Register offsets
`define NSP_REG_CTRL 8'h00
`define NSP_REG_ROW 8'h04
`define NSP_REG_COL 8'h08
`define NSP_REG_COUNT 8'h0c
`define NSP_REG_STAT 8'h10
`define NSP_REG_DATA 8'h14

// Control fields
`define NSP_CTRL_OP_LSB 0
`define NSP_CTRL_OTP_BIT 3

// Device command codes
`define NSP_CMD_STATUS 8'h70
`define NSP_CMD_ESTATUS 8'h78
`define NSP_CMD_READMODE 8'h00
`define NSP_CMD_PARAM 8'hec
`define NSP_CMD_PSEL 8'h06
`define NSP_CMD_PSEL_CONF 8'he0
`define NSP_PARAM_ADDR 8'h00

// Status byte bit positions
`define NSP_SR_FAIL 0
`define NSP_SR_PERR 1
`define NSP_SR_RDY_ARR 5
`define NSP_SR_RDY 6
`define NSP_SR_WP_N 7

// Expected parameter page fields (little-endian values)
`define NSP_PP_SPARE_PAGE 16'h0040
`define NSP_PP_DATA_PART 32'h00000200
`define NSP_PP_SPARE_PART 16'h0010
`define NSP_PP_PAGES_BLK 32'h00000040
`define NSP_PP_BLKS_LUN 32'h00001000
`define NSP_PP_LUNS 8'h02
`define NSP_PP_BAD_MAX 16'h0050
`define NSP_PP_NOP 8'h04
`define NSP_PP_PART_ATTR 8'h00
`define NSP_PP_ECC_BITS 8'h04
`define NSP_PP_ILV_BITS 8'h01
`define NSP_PP_ILV_ATTR 8'h00
`define NSP_PP_T_PROG 16'h02bc
`define NSP_PP_T_ERASE 16'h2710
`define NSP_PP_T_READ 16'h0019
`define NSP_PP_CCS_MIN 16'h0046
`define NSP_PP_COPY_LEN 12'd256
`define NSP_PP_COPY_END 12'd768

// Timing
`define NSP_CLK_NS 25
`define NSP_STB_LO_CYC 4'd4
`define NSP_STB_HI_CYC 4'd2
`define NSP_WHR_NS 80
`define NSP_WHR_CYC 8'((`NSP_WHR_NS + `NSP_CLK_NS - 1) / `NSP_CLK_NS)
`define NSP_WB_NS 100
`define NSP_WB_CYC 8'((`NSP_WB_NS + `NSP_CLK_NS - 1) / `NSP_CLK_NS)

`endif

//--- nsp_pkg.sv
package nsp_pkg;
   typedef enum logic [2:0] {OP_STATUS, OP_ESTATUS, OP_READMODE, OP_PARAM, OP_PSEL,
                             OP_DATA} nsp_op_e;
   typedef enum logic [1:0] {KIND_CMD, KIND_ADDR, KIND_READ} nsp_kind_e;
   typedef enum logic [3:0] {ST_IDLE, ST_PRE_RDY, ST_CMD1, ST_ADDR, ST_CMD2, ST_TWAIT,
                             ST_RDY, ST_READ, ST_DONE} nsp_state_e;
   typedef struct packed {
      nsp_kind_e kind;
      logic [7:0] data;
   } nsp_req_s;
   typedef struct packed {
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
      logic io_oe;
      logic [7:0] io;
   } nsp_pins_s;
endpackage

//--- nsp_cycle.sv
`timescale 1ns/100ps
`include "nsp_cfg.svh"
module nsp_cycle
   import nsp_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Request
   input wire logic start_in,
   input wire nsp_req_s req_in,
   output logic done_out,
   output logic [7:0] rd_data_out,
   // Synchronised bus input
   input wire logic [7:0] io_sync_in,
   // Pins
   output nsp_pins_s pins_out
);
   typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} nsp_cyc_e;
   nsp_cyc_e st_r, st_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic done_r, done_nxt;
   logic [7:0] rd_r, rd_nxt;
   nsp_pins_s pins_r, pins_nxt;
   nsp_kind_e kind_r, kind_nxt;

   assign done_out = done_r;
   assign rd_data_out = rd_r;
   assign pins_out = pins_r;

   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      rd_nxt = rd_r;
      pins_nxt = pins_r;
      kind_nxt = kind_r;
      case (st_r)
         C_IDLE:
         begin
            if (start_in)
            begin
               kind_nxt = req_in.kind;
               pins_nxt.cle = (req_in.kind == KIND_CMD);
               pins_nxt.ale = (req_in.kind == KIND_ADDR);
               pins_nxt.io_oe = (req_in.kind != KIND_READ);
               pins_nxt.io = req_in.data;
               pins_nxt.we_n = (req_in.kind == KIND_READ);
               pins_nxt.re_n = (req_in.kind != KIND_READ);
               cnt_nxt = `NSP_STB_LO_CYC;
               st_nxt = C_LOW;
            end
         end
         C_LOW:
         begin
            cnt_nxt = cnt_r - 4'd1;
            if (cnt_r == 4'd1)
            begin
               // Sample late so the two-stage input path has settled
               if (kind_r == KIND_READ)
                  rd_nxt = io_sync_in;
               pins_nxt.we_n = 1'b1;
               pins_nxt.re_n = 1'b1;
               cnt_nxt = `NSP_STB_HI_CYC;
               st_nxt = C_HIGH;
            end
         end
         default:
         begin
            cnt_nxt = cnt_r - 4'd1;
            if (cnt_r == 4'd1)
            begin
               pins_nxt.cle = 1'b0;
               pins_nxt.ale = 1'b0;
               pins_nxt.io_oe = 1'b0;
               done_nxt = 1'b1;
               st_nxt = C_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= C_IDLE;
         cnt_r <= 4'h0;
         done_r <= 1'b0;
         rd_r <= 8'h00;
         pins_r <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, io_oe: 1'b0, io: 8'h00};
         kind_r <= KIND_CMD;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
         rd_r <= rd_nxt;
         pins_r <= pins_nxt;
         kind_r <= kind_nxt;
      end
   end
endmodule

//--- nsp_host_checker.sv
`timescale 1ns/100ps
`include "nsp_cfg.svh"
module nsp_host_checker (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rdata_out,
   // Device pins
   input wire logic ce_n_out,
   input wire logic cle_out,
   input wire logic ale_out,
   input wire logic we_n_out,
   input wire logic read_strobe_n_out,
   input wire logic [7:0] io_out,
   input wire logic io_oe_out,
   input wire logic [7:0] io_in,
   input wire logic ready_in
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence cmd_s(logic [7:0] c);
      $fell(we_n_out) && cle_out && io_out == c;
   endsequence

   reset_idle_a:
      assert property (disable iff (1'b0) !rst_n_in |=> ce_n_out && we_n_out
         && read_strobe_n_out && !io_oe_out) else $error("pins active in reset");
   rdata_idle_a:
      assert property (!rd_in |=> rdata_out == 32'h0) else $error("stale read data");
   write_pulse_a:
      assert property ($fell(we_n_out) |-> !we_n_out [*4] ##1 we_n_out)
         else $error("write strobe length");
   read_pulse_a:
      assert property ($fell(read_strobe_n_out) |-> !read_strobe_n_out [*4] ##1
         read_strobe_n_out) else $error("read strobe length");
   write_hold_a:
      assert property ($fell(we_n_out) |=> ($stable(io_out) && $stable(cle_out)
         && $stable(ale_out) && io_oe_out) [*5]) else $error("write cycle not held");
   one_latch_a:
      assert property (!we_n_out |-> io_oe_out && cle_out != ale_out && !ce_n_out)
         else $error("bad latch select");
   read_release_a:
      assert property (!read_strobe_n_out |-> !io_oe_out && !ce_n_out && we_n_out)
         else $error("bus driven during read");
   status_read_a:
      assert property (cmd_s(`NSP_CMD_STATUS) |-> ##[5:40] $fell(read_strobe_n_out))
         else $error("no read after status");
   row_follow_a:
      assert property (cmd_s(`NSP_CMD_ESTATUS) |-> ##[5:20] ($fell(we_n_out) && ale_out))
         else $error("no row address after 78h");
   psel_ready_a:
      assert property (cmd_s(`NSP_CMD_PSEL) |-> $past(ready_in, 2))
         else $error("plane select while busy");
   otp_quiet_a:
      assert property (wr_in && addr_in == `NSP_REG_CTRL && wdata_in[3:0] == 4'h9
         && ce_n_out |=> ce_n_out [*8]) else $error("78h sent in otp mode");

   cover property (cmd_s(`NSP_CMD_STATUS));
   cover property (cmd_s(`NSP_CMD_ESTATUS));
   cover property (cmd_s(`NSP_CMD_PSEL));
endmodule

bind nsp_host nsp_host_checker chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .ce_n_out(ce_n_out), .cle_out(cle_out), .ale_out(ale_out),
   .we_n_out(we_n_out), .read_strobe_n_out(read_strobe_n_out), .io_out(io_out),
   .io_oe_out(io_oe_out), .io_in(io_in), .ready_in(ready_in));

//--- nsp_dev_model.sv
`timescale 1ns/100ps
module nsp_dev_model (
   // Host pins
   input wire logic ce_n_in,
   input wire logic cle_in,
   input wire logic ale_in,
   input wire logic we_n_in,
   input wire logic read_strobe_n_in,
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic ready_out,
   // Bench controls
   input wire logic busy_in,
   input wire logic prot_in,
   input wire logic [3:0] fail_in
);
   // Mode 0 data, 1 status, 2 enhanced status, 3 parameter page
   logic [1:0] mode = 2'd0;
   logic [7:0] last_cmd = 8'h0;
   logic [7:0] last_out = 8'h0;
   logic [7:0] cur;
   logic [11:0] pos = 12'h0;
   logic plane = 1'b0;
   logic rdy_p = 1'b1;
   int n_addr = 0;

   function automatic logic [7:0] pp_byte(input logic [7:0] p);
      case (p)
         8'd84, 8'd92: return 8'h40;
         8'd87, 8'd100, 8'd134: return 8'h02;
         8'd90, 8'd97, 8'd135: return 8'h10;
         8'd102, 8'd105, 8'd107, 8'd113: return 8'h01;
         8'd110, 8'd112: return 8'h04;
         8'd101: return 8'h23;
         8'd103: return 8'h50;
         8'd106: return 8'h05;
         8'd128: return 8'h0a;
         8'd129: return 8'h1f;
         8'd133: return 8'hbc;
         8'd136: return 8'h27;
         8'd137: return 8'h19;
         8'd139: return 8'h46;
         default: return 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////
   assign ready_out = rdy_p & ~busy_in;
   always_comb
      if (mode == 2'd1)
         cur = {~prot_in, {2{ready_out}}, 3'h0, fail_in[1] | fail_in[3], fail_in[0] | fail_in[2]};
      else if (mode == 2'd2)
         cur = {~prot_in, {2{ready_out}}, 3'h0, fail_in[{plane, 1'b1}], fail_in[{plane, 1'b0}]};
      else if (mode == 2'd3)
         cur = pp_byte(pos[7:0]);
      else
         cur = pos[7:0] ^ 8'h5a;
   // Released bus shows the inverse of the last byte, never a stale copy
   assign io_out = (!ce_n_in && !read_strobe_n_in) ? cur : ~last_out;

   always @(posedge we_n_in)
      if (!ce_n_in && cle_in)
      begin
         last_cmd <= io_in;
         n_addr <= 0;
         pos <= 12'h0;
         case (io_in)
            8'h70: mode <= 2'd1;
            8'h78: mode <= 2'd2;
            8'hec:
            begin
               mode <= 2'd3;
               rdy_p <= 1'b0;
               rdy_p <= #500 1'b1;
            end
            default: mode <= 2'd0;
         endcase
      end
      else if (!ce_n_in && ale_in)
      begin
         if (mode == 2'd2 && n_addr == 0)
            plane <= io_in[6];
         n_addr <= n_addr + 1;
      end

   always @(posedge read_strobe_n_in)
      if (!ce_n_in)
      begin
         last_out <= cur;
         pos <= pos + 12'h1;
      end
endmodule

//--- nsp_host_test.sv
`timescale 1ns/100ps
`include "nsp_cfg.svh"
module nsp_host_test;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] addr_in = 8'h0;
   logic [31:0] wdata_in = 32'h0;
   logic [31:0] rdata_out;
   logic ce_n, cle, ale, we_n, re_n, io_oe, ready, p, pl;
   logic busy = 1'b0;
   logic prot = 1'b0;
   logic [3:0] fail = 4'h0;
   logic [3:0] f;
   logic [7:0] io_h, io_d, sb;
   logic [63:0] e;
   logic [63:0] exp_q[$];
   int n_mismatch = 0;
   int checks_done = 0;
   int seed = 80;
   int i;
   wire [7:0] io_w = io_oe ? io_h : io_d;

   nsp_host dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .ce_n_out(ce_n), .cle_out(cle), .ale_out(ale), .we_n_out(we_n),
      .read_strobe_n_out(re_n), .io_out(io_h), .io_oe_out(io_oe), .io_in(io_w),
      .ready_in(ready));
   nsp_dev_model dev_u (.ce_n_in(ce_n), .cle_in(cle), .ale_in(ale), .we_n_in(we_n),
      .read_strobe_n_in(re_n), .io_in(io_w), .io_out(io_d), .ready_out(ready),
      .busy_in(busy), .prot_in(prot), .fail_in(fail));

   initial
      forever #12.5 clk_in = ~clk_in;

   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] s);
      checks_done++;
      if (s !== ex)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, ex, s);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   // Mask in the upper half keeps unspecified fields out of the compare
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
      exp_q.push_back({m, ex});
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
   endtask

   task automatic idle();
      int k;
      k = 0;
      // Chip select falls after the write lands, and for plane select only once ready syncs
      repeat (4) @(posedge clk_in);
      while (!ce_n && k < 20000)
      begin
         @(posedge clk_in);
         k++;
      end
      chk("op finished", 32'h1, {31'h0, ce_n});
      repeat (2) @(posedge clk_in);
   endtask

   task automatic op(input logic [31:0] c);
      wr(`NSP_REG_CTRL, c);
      idle();
   endtask

   task automatic print_verdict();
      if (n_mismatch == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      rd_d <= rd_in;
      if (rd_d)
      begin
         e = exp_q.pop_front();
         chk("register read", e[31:0], rdata_out & e[63:32]);
      end
   end

   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(`NSP_REG_STAT, 32'h0, 32'h7);
      rd(8'h3c, 32'h0, 32'hffffffff);
      // Even passes plain status when ready, odd passes per-plane status while busy
      for (i = 0; i < 6; i++)
      begin
         f = 4'($random(seed));
         p = 1'($random(seed));
         pl = 1'($random(seed));
         fail <= f;
         prot <= p;
         busy <= i[0];
         wr(`NSP_REG_ROW, {25'h0, pl, 6'h0});
         op({31'h0, i[0]});
         sb = i[0] ? {~p, 5'h00, f[{pl, 1'b1}], f[{pl, 1'b0}]}
            : {~p, 5'h18, f[1] | f[3], f[0] | f[2]};
         rd(`NSP_REG_STAT, {11'h0, ~sb[7], sb[1], sb[0], sb[5], sb[6], sb, 8'h08},
            32'h001fff0f);
      end
      busy <= 1'b0;
      wr(`NSP_REG_COUNT, 32'd3);
      op(32'd5);
      rd(`NSP_REG_DATA, {4'h0, 12'd3, 16'h0058}, 32'h0fff00ff);
      wr(`NSP_REG_COUNT, 32'd653);
      op(32'd3);
      rd(`NSP_REG_STAT, 32'h0, 32'hf);
      rd(`NSP_REG_DATA, {4'h0, 12'd653, 16'h0}, 32'h0fff00ff);
      busy <= 1'b1;
      wr(`NSP_REG_COL, 32'h10);
      wr(`NSP_REG_CTRL, 32'd4);
      repeat (40) @(posedge clk_in);
      chk("plane select early", 32'h0, {31'h0, dev_u.last_cmd == `NSP_CMD_PSEL});
      busy <= 1'b0;
      idle();
      chk("plane confirm", {24'h0, `NSP_CMD_PSEL_CONF}, {24'h0, dev_u.last_cmd});
      op(32'h9);
      rd(`NSP_REG_STAT, 32'h2, 32'h3);
      repeat (3) @(posedge clk_in);
      print_verdict();
   end

   initial
   begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end
endmodule
